// file: logic/glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
module glitch_filter (
  input  wire logic                           clk,
  input  wire logic                           srst,
  input  wire logic                           din,
  input  wire logic [i2c_cc_pkg::FILT_W-1:0]  depth,
  input  wire logic                           reload,
  output logic                                dout
);
  import i2c_cc_pkg::*;

  typedef struct packed {
    logic              dout;
    logic [FILT_W-1:0] cnt;
  } st_s;

  st_s r;
  st_s n;

  always_comb begin
    n = r;
    if (reload || (din == r.dout)) begin
      n.cnt = '0;
    end else if (r.cnt >= depth) begin
      n.dout = din;
      n.cnt  = '0;
    end else begin
      n.cnt = r.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{dout: 1'b1, cnt: '0};
    end else begin
      r <= n;
    end
  end

  assign dout = r.dout;
endmodule
`default_nettype wire

// file: logic/i2c_cc_pkg.sv
`default_nettype none
package i2c_cc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FWD_FILT = 8'h17;
  localparam logic [7:0] ADDR_HIGH     = 8'h18;
  localparam logic [7:0] ADDR_LOW      = 8'h19;

  // reset values
  localparam logic [7:0] RST_FWD_FILT  = 8'h1E;
  localparam logic [7:0] RST_HIGH      = 8'h7F;
  localparam logic [7:0] RST_LOW       = 8'h7F;

  // field positions in the forward and filter register
  localparam int FWD_ALL_BIT = 7;
  localparam int HOLD_MSB    = 6;
  localparam int HOLD_LSB    = 4;
  localparam int FILT_MSB    = 3;
  localparam int FILT_LSB    = 0;

  // timing, in picoseconds; PHASE_EXTRA in oscillator units
  localparam int CLK_PERIOD_PS = 50000;
  localparam int HOLD_UNIT_PS  = 40000;
  localparam int FILT_UNIT_PS  = 5000;
  localparam int OSC_UNIT_PS   = 40000;
  localparam int PHASE_EXTRA   = 5;

  // counter widths and sda delay line length
  localparam int PH_W   = 9;
  localparam int FILT_W = 2;
  localparam int DLY_N  = 8;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_LOW  = 3'b010,
    CTL_HIGH = 3'b100
  } ctl_e;

  typedef enum logic [1:0] {
    TGT_IDLE  = 2'b01,
    TGT_SETUP = 2'b10
  } tgt_e;

  // phase length: (count + extra) oscillator units, rounded up to clock cycles
  function automatic logic [PH_W-1:0] phase_cycles(input logic [7:0] cnt);
    int ps;
    ps = (int'(cnt) + PHASE_EXTRA) * OSC_UNIT_PS;
    return PH_W'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction

  // sda hold delay in clock cycles, rounded up
  function automatic logic [2:0] hold_cycles(input logic [2:0] f);
    int ps;
    ps = int'(f) * HOLD_UNIT_PS;
    return 3'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction

  // glitch width to reject, in clock cycles, rounded up
  function automatic logic [FILT_W-1:0] filt_cycles(input logic [3:0] f);
    int ps;
    ps = int'(f) * FILT_UNIT_PS;
    return FILT_W'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction

endpackage
`default_nettype wire

// file: logic/i2c_cc_timing.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] forward-all set: forward every access whose target differs from own ID
// [R2] forward-all clear: forward only remote deserializer or remote target IDs
// [R3] forward-all kept per port; accesses reach port 1 copy when selected
// [R4] sda input delayed by hold field times 40 ns; field resets to 1
// [R5] scl and sda glitches up to filter field times 5 ns rejected; reset 14
// [R6] as controller, scl high for high-time count in 40 ns units; reset 127
// [R7] as controller, scl low for low-time count in 40 ns units; reset 127
// [R8] each scl phase lasts programmed count plus five extra units
// [R9] as target, scl held low for low-time after data presented, then released
// [R10] reset counts give at least 5 us per phase even with fast oscillator
// [R11] hold, filter and phase timing restart when its field is written
module i2c_cc_timing (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        SECOND_PORT_SELECT,
  input  wire logic        SCL_PIN,
  input  wire logic        SDA_PIN,
  output logic             SCL_FILT,
  output logic             SDA_FILT,
  input  wire logic        CTRL_ENABLE,
  input  wire logic        TGT_DATA_READY,
  output logic             SCL_OE,
  output logic             SCL_PHASE_HIGH,
  output logic             SETUP_DONE,
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_PORT,
  input  wire logic [6:0]  ACC_TARGET_ID,
  input  wire logic [6:0]  OWN_ID,
  input  wire logic [6:0]  REMOTE_DESER_ID,
  input  wire logic [6:0]  REMOTE_TARGET_ID,
  output logic             FWD_VALID,
  output logic             FWD_PASS
);
  import i2c_cc_pkg::*;

  typedef struct packed {
    logic             fwd_all0;
    logic             fwd_all1;
    logic [2:0]       hold;
    logic [3:0]       filt;
    logic [7:0]       high;
    logic [7:0]       low;
    logic [7:0]       rdata;
    logic             fwd_valid;
    logic             fwd_pass;
    ctl_e             ctl;
    tgt_e             tgt;
    logic             scl_oe;
    logic             scl_high;
    logic             setup_done;
    logic [DLY_N-1:0] sda_dly;
    logic             sda_held;
    logic             scl_held;
    logic             scl_s1;
    logic             scl_s2;
    logic             sda_s1;
    logic             sda_s2;
  } st_s;

  st_s r;
  st_s n;

  logic [1:0]      pin_sync;
  logic [1:0]      pin_filt;
  logic            filt_reload;
  logic            wr_ff;
  logic            wr_high;
  logic            wr_low;
  logic            ctl_start;
  logic [PH_W-1:0] ctl_len;
  logic            ctl_done;
  logic            tgt_start;
  logic            tgt_done;
  logic            sel_all;
  logic [2:0]      hcyc;

  // address decode, one strobe per mapped register
  assign wr_ff       = REG_WR && (REG_ADDR == ADDR_FWD_FILT);
  assign wr_high     = REG_WR && (REG_ADDR == ADDR_HIGH);
  assign wr_low      = REG_WR && (REG_ADDR == ADDR_LOW);
  assign filt_reload = wr_ff; // [R11]
  assign pin_sync    = {r.sda_s2, r.scl_s2};

  // one glitch filter per pin: scl at index 0, sda at index 1
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      glitch_filter u_filt (
        .clk    (CLK_SYS),
        .srst   (SRST),
        .din    (pin_sync[gi]),
        .depth  (filt_cycles(r.filt)), // [R5]
        .reload (filt_reload),
        .dout   (pin_filt[gi])
      );
    end
  endgenerate

  // controller phase timer, restarted at every phase edge
  phase_timer u_ctl_timer (
    .clk    (CLK_SYS),
    .srst   (SRST),
    .start  (ctl_start),
    .length (ctl_len),
    .busy   (),
    .done   (ctl_done)
  );

  // target setup timer; its length follows the low-time field
  phase_timer u_tgt_timer (
    .clk    (CLK_SYS),
    .srst   (SRST),
    .start  (tgt_start),
    .length (phase_cycles(n.low)), // [R9]
    .busy   (),
    .done   (tgt_done)
  );

  always_comb begin
    n            = r;
    ctl_start    = 1'b0;
    tgt_start    = 1'b0;
    ctl_len      = '0;
    sel_all      = 1'b0;
    hcyc         = 3'h0;
    n.fwd_valid  = 1'b0;
    n.setup_done = 1'b0;

    // pin synchronisers
    n.scl_s1 = SCL_PIN;
    n.scl_s2 = r.scl_s1;
    n.sda_s1 = SDA_PIN;
    n.sda_s2 = r.sda_s1;

    // register writes
    if (wr_ff) begin
      if (SECOND_PORT_SELECT) begin
        n.fwd_all1 = REG_WDATA[FWD_ALL_BIT]; // [R3]
      end else begin
        n.fwd_all0 = REG_WDATA[FWD_ALL_BIT]; // [R3]
      end
      n.hold = REG_WDATA[HOLD_MSB:HOLD_LSB];
      n.filt = REG_WDATA[FILT_MSB:FILT_LSB];
    end
    if (wr_high) begin
      n.high = REG_WDATA;
    end
    if (wr_low) begin
      n.low = REG_WDATA;
    end

    // register reads
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_FWD_FILT: begin
          n.rdata = {(SECOND_PORT_SELECT ? r.fwd_all1 : r.fwd_all0), r.hold, r.filt}; // [R3]
        end
        ADDR_HIGH: begin
          n.rdata = r.high;
        end
        ADDR_LOW: begin
          n.rdata = r.low;
        end
        default: begin
          n.rdata = 8'h00;
        end
      endcase
    end

    // forwarding decision
    if (ACC_VALID) begin
      sel_all     = ACC_PORT ? r.fwd_all1 : r.fwd_all0; // [R3]
      n.fwd_valid = 1'b1;
      // own id is never forwarded, even with forward-all set
      if (ACC_TARGET_ID == OWN_ID) begin
        n.fwd_pass = 1'b0;
      end else if (sel_all) begin
        n.fwd_pass = 1'b1; // [R1]
      end else begin
        n.fwd_pass = (ACC_TARGET_ID == REMOTE_DESER_ID) ||
                     (ACC_TARGET_ID == REMOTE_TARGET_ID); // [R2]
      end
    end

    // scl takes one register stage too, so only the hold field separates the two
    n.scl_held = pin_filt[0]; // [R4]

    // sda hold delay after filtering
    hcyc      = hold_cycles(r.hold);
    n.sda_dly = {r.sda_dly[DLY_N-2:0], pin_filt[1]};
    if (wr_ff) begin
      n.sda_dly = {DLY_N{pin_filt[1]}}; // [R11]
    end
    if (hcyc == 3'h0) begin
      n.sda_held = pin_filt[1];
    end else begin
      n.sda_held = r.sda_dly[hcyc - 3'h1]; // [R4]
    end

    // controller scl phases
    case (r.ctl)
      CTL_IDLE: begin
        if (CTRL_ENABLE) begin
          n.ctl     = CTL_LOW;
          ctl_start = 1'b1;
        end
      end
      CTL_LOW: begin
        if (wr_low) begin
          ctl_start = 1'b1; // [R11]
        end else if (ctl_done) begin
          n.ctl     = CTL_HIGH;
          ctl_start = 1'b1;
        end
      end
      CTL_HIGH: begin
        if (wr_high) begin
          ctl_start = 1'b1; // [R11]
        end else if (ctl_done) begin
          if (CTRL_ENABLE) begin
            n.ctl     = CTL_LOW;
            ctl_start = 1'b1;
          end else begin
            n.ctl = CTL_IDLE;
          end
        end
      end
      default: begin
        n.ctl = CTL_IDLE;
      end
    endcase
    if (n.ctl == CTL_HIGH) begin
      ctl_len = phase_cycles(n.high); // [R6] [R8] [R10]
    end else begin
      ctl_len = phase_cycles(n.low); // [R7] [R8] [R10]
    end

    // target setup before releasing stretched scl
    case (r.tgt)
      TGT_IDLE: begin
        if (TGT_DATA_READY) begin
          n.tgt     = TGT_SETUP;
          tgt_start = 1'b1; // [R9]
        end
      end
      TGT_SETUP: begin
        if (wr_low) begin
          tgt_start = 1'b1; // [R11]
        end else if (tgt_done) begin
          n.tgt        = TGT_IDLE;
          n.setup_done = 1'b1; // [R9]
        end
      end
      default: begin
        n.tgt = TGT_IDLE;
      end
    endcase

    n.scl_oe   = (n.ctl == CTL_LOW) || (n.tgt == TGT_SETUP); // [R7] [R9]
    n.scl_high = (n.ctl == CTL_HIGH); // [R6]
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      r          <= '0;
      r.fwd_all0 <= RST_FWD_FILT[FWD_ALL_BIT];
      r.fwd_all1 <= RST_FWD_FILT[FWD_ALL_BIT];
      r.hold     <= RST_FWD_FILT[HOLD_MSB:HOLD_LSB]; // [R4]
      r.filt     <= RST_FWD_FILT[FILT_MSB:FILT_LSB]; // [R5]
      r.high     <= RST_HIGH; // [R10]
      r.low      <= RST_LOW; // [R10]
      r.ctl      <= CTL_IDLE;
      r.tgt      <= TGT_IDLE;
      // pins idle high, so filters and delay line start released
      r.scl_held <= 1'b1;
      r.sda_dly  <= '1;
      r.sda_held <= 1'b1;
      r.scl_s1   <= 1'b1;
      r.scl_s2   <= 1'b1;
      r.sda_s1   <= 1'b1;
      r.sda_s2   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign REG_RDATA      = r.rdata;
  assign SCL_FILT       = r.scl_held;
  assign SDA_FILT       = r.sda_held;
  assign SCL_OE         = r.scl_oe;
  assign SCL_PHASE_HIGH = r.scl_high;
  assign SETUP_DONE     = r.setup_done;
  assign FWD_VALID      = r.fwd_valid;
  assign FWD_PASS       = r.fwd_pass;
endmodule
`default_nettype wire

// file: logic/phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         start,
  input  wire logic [i2c_cc_pkg::PH_W-1:0]  length,
  output logic                              busy,
  output logic                              done
);
  import i2c_cc_pkg::*;

  typedef struct packed {
    logic [PH_W-1:0] cnt;
    logic            busy;
    logic            done;
  } st_s;

  st_s r;
  st_s n;

  always_comb begin
    n      = r;
    n.done = 1'b0;
    if (start) begin
      n.cnt  = length - PH_W'(1);
      n.busy = 1'b1;
    end else if (r.busy) begin
      if (r.cnt == '0) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = r.cnt - PH_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy = r.busy;
  assign done = r.done;
endmodule
`default_nettype wire

// file: verif/i2c_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
  input  wire logic scl_oe,
  input  wire logic scl_pull,
  input  wire logic sda_pull,
  output logic      scl_line,
  output logic      sda_line
);
  // open-drain lines with pull-ups: low while any party pulls
  assign scl_line = !(scl_oe || scl_pull);
  assign sda_line = !sda_pull;
endmodule
`default_nettype wire

// file: verif/i2c_cc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_cc_checker (
  input wire logic       CLK_SYS,
  input wire logic       SRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       ACC_VALID,
  input wire logic [6:0] ACC_TARGET_ID,
  input wire logic [6:0] OWN_ID,
  input wire logic       FWD_VALID,
  input wire logic       FWD_PASS,
  input wire logic       SCL_OE,
  input wire logic       SCL_PHASE_HIGH,
  input wire logic       SETUP_DONE
);
  import i2c_cc_pkg::*;
  logic [8:0] oe_cnt_r;
  logic [8:0] oe_cnt_nxt;
  logic       unmapped_rd;
  // length of the current low drive on scl
  always_comb oe_cnt_nxt = SCL_OE ? oe_cnt_r + 9'h001 : 9'h000;
  always_ff @(posedge CLK_SYS) oe_cnt_r <= SRST ? 9'h000 : oe_cnt_nxt;
  // read of an address outside the map
  assign unmapped_rd = REG_RD && !(REG_ADDR inside {ADDR_FWD_FILT, ADDR_HIGH, ADDR_LOW});
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  a_fwd_answer: assert property (ACC_VALID |=> FWD_VALID)
    else $error("no forward answer");
  a_fwd_spurious: assert property (!ACC_VALID |=> !FWD_VALID)
    else $error("forward answer without access");
  a_own_blocked: assert property (ACC_VALID && ACC_TARGET_ID == OWN_ID |=> !FWD_PASS)
    else $error("own id forwarded");
  a_pass_held: assert property (!ACC_VALID |=> $stable(FWD_PASS))
    else $error("forward decision changed");
  a_unmapped_zero: assert property (unmapped_rd |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_held: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed");
  a_low_min: assert property ($rose(SCL_OE) |-> SCL_OE[*4])
    else $error("low phase too short");
  a_high_min: assert property ($rose(SCL_PHASE_HIGH) |-> SCL_PHASE_HIGH[*4])
    else $error("high phase too short");
  a_high_released: assert property (SCL_PHASE_HIGH |-> !SCL_OE)
    else $error("scl driven in high phase");
  a_setup_end: assert property (SETUP_DONE |-> !SCL_OE && $past(SCL_OE))
    else $error("scl not released at setup end");
  a_setup_pulse: assert property (SETUP_DONE |=> !SETUP_DONE)
    else $error("setup done too long");
  a_low_max: assert property (oe_cnt_r <= 9'h0D2)
    else $error("low phase too long");
  c_pass: cover property (ACC_VALID ##1 FWD_PASS);
  c_high_end: cover property ($fell(SCL_PHASE_HIGH));
  c_setup: cover property (SETUP_DONE);
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk, srst, reg_wr, reg_rd, sel2, ctrl_en, tgt_rdy, acc_v, acc_p;
  logic       scl_pull, sda_pull, scl_pin, sda_pin, scl_filt, sda_filt;
  logic       scl_oe, ph_hi, setup_done, fwd_v, fwd_p;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic [6:0] acc_id, own_id, des_id, rtg_id;
  int         err_total, tests_run;
  i2c_cc_timing i_i2c_cc_timing (.CLK_SYS(clk), .SRST(srst), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .SECOND_PORT_SELECT(sel2), .SCL_PIN(scl_pin), .SDA_PIN(sda_pin), .SCL_FILT(scl_filt),
    .SDA_FILT(sda_filt), .CTRL_ENABLE(ctrl_en), .TGT_DATA_READY(tgt_rdy), .SCL_OE(scl_oe),
    .SCL_PHASE_HIGH(ph_hi), .SETUP_DONE(setup_done), .ACC_VALID(acc_v), .ACC_PORT(acc_p),
    .ACC_TARGET_ID(acc_id), .OWN_ID(own_id), .REMOTE_DESER_ID(des_id),
    .REMOTE_TARGET_ID(rtg_id), .FWD_VALID(fwd_v), .FWD_PASS(fwd_p));
  i2c_bus_model i_i2c_bus_model (.scl_oe(scl_oe), .scl_pull(scl_pull), .sda_pull(sda_pull),
    .scl_line(scl_pin), .sda_line(sda_pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic rep(input bit ok, input logic [8:0] g, input logic [8:0] e);
    tests_run++;
    if (!ok) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    rep(g === e, {1'b0, g}, {1'b0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic fw(input logic p, input logic [6:0] id, input logic e);
    @(posedge clk);
    acc_v <= 1'b1;
    acc_p <= p;
    acc_id <= id;
    @(posedge clk);
    acc_v <= 1'b0;
    #1;
    chk({6'h00, fwd_v, fwd_p}, {6'h00, 1'b1, e});
  endtask
  // waits for the phase to start, then counts its cycles
  task automatic len(input bit s, input int lo);
    int n;
    int k;
    k = 0;
    n = 0;
    #1;
    while ((s ? ph_hi : scl_oe) !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    while ((s ? ph_hi : scl_oe) === 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (k >= 300 || n >= 300) begin
      err_total++;
      give_verdict();
    end
    rep(n >= lo && n <= lo + 2, 9'(n), 9'(lo));
  endtask
  task automatic idle();
    int k;
    k = 0;
    while ((scl_oe | ph_hi) !== 1'b0 && k < 600) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 600) begin
      err_total++;
      give_verdict();
    end
    chk({7'h00, scl_oe | ph_hi}, 8'h00);
  endtask
  // pulls one line low for w cycles and reports whether the filter passed it
  task automatic gl(input bit s, input int w, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    if (s) sda_pull <= 1'b1;
    else scl_pull <= 1'b1;
    repeat (w) @(posedge clk);
    scl_pull <= 1'b0;
    sda_pull <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      #1;
      if ((s ? sda_filt : scl_filt) === 1'b0) seen = 1'b1;
    end
    chk({7'h00, seen}, {7'h00, e});
  endtask
  // pulls both lines together and counts cycles by which sda trails scl
  task automatic hd(input int lo);
    int k;
    int n;
    k = 0;
    n = 0;
    @(posedge clk);
    scl_pull <= 1'b1;
    sda_pull <= 1'b1;
    while (scl_filt !== 1'b0 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (sda_filt !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (k >= 20 || n >= 20) begin
      err_total++;
      give_verdict();
    end
    rep(n >= lo && n <= lo + 1, 9'(n), 9'(lo));
    @(posedge clk);
    scl_pull <= 1'b0;
    sda_pull <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {srst, reg_wr, reg_rd, sel2, ctrl_en, tgt_rdy, acc_v, acc_p} = 8'h80;
    {scl_pull, sda_pull, reg_addr, reg_wdata, acc_id} = '0;
    own_id = 7'h3A;
    des_id = 7'h2C;
    rtg_id = 7'h50;
    err_total = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(8'h17, 8'h1E);
    rd(8'h18, 8'h7F);
    rd(8'h19, 8'h7F);
    @(posedge clk);
    ctrl_en <= 1'b1;
    len(0, 106);
    len(1, 106);
    @(posedge clk);
    ctrl_en <= 1'b0;
    idle();
    gl(0, 1, 1'b0);
    gl(0, 6, 1'b1);
    gl(1, 1, 1'b0);
    gl(1, 6, 1'b1);
    hd(1);
    wr(8'h17, 8'h7E);
    hd(6);
    wr(8'h17, 8'h10);
    gl(0, 1, 1'b1);
    wr(8'h33, 8'hA5);
    rd(8'h33, 8'h00);
    @(posedge clk);
    sel2 <= 1'b1;
    wr(8'h17, 8'h9E);
    rd(8'h17, 8'h9E);
    @(posedge clk);
    sel2 <= 1'b0;
    rd(8'h17, 8'h1E);
    fw(0, 7'h11, 1'b0);
    fw(0, des_id, 1'b1);
    fw(0, rtg_id, 1'b1);
    fw(1, 7'h11, 1'b1);
    fw(1, own_id, 1'b0);
    wr(8'h17, 8'h9E);
    fw(0, 7'h11, 1'b1);
    fw(0, own_id, 1'b0);
    wr(8'h19, 8'h0A);
    wr(8'h18, 8'h14);
    rd(8'h19, 8'h0A);
    @(posedge clk);
    ctrl_en <= 1'b1;
    len(0, 12);
    len(1, 20);
    @(posedge clk);
    ctrl_en <= 1'b0;
    idle();
    @(posedge clk);
    tgt_rdy <= 1'b1;
    @(posedge clk);
    tgt_rdy <= 1'b0;
    len(0, 12);
    chk({7'h00, setup_done}, 8'h01);
    give_verdict();
  end
endmodule
bind i2c_cc_timing i2c_cc_checker u_chk (.CLK_SYS(CLK_SYS), .SRST(SRST), .REG_ADDR(REG_ADDR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC_VALID(ACC_VALID),
  .ACC_TARGET_ID(ACC_TARGET_ID), .OWN_ID(OWN_ID), .FWD_VALID(FWD_VALID),
  .FWD_PASS(FWD_PASS), .SCL_OE(SCL_OE), .SCL_PHASE_HIGH(SCL_PHASE_HIGH),
  .SETUP_DONE(SETUP_DONE));
`default_nettype wire
